/* asc_sram_regs.vh */
/*
 * timing figures and derived cycle counts for the async sram host controller.
 * assumes a 20 MHz core clock; times are in ns per speed grade.
 */
`ifndef ASC_SRAM_REGS_VH
`define ASC_SRAM_REGS_VH
`define ASC_CLK_PERIOD_NS 50
`define ASC_ADDR_W 12
`define ASC_DATA_W 4
// grade codes
`define ASC_GRADE_25 2'h0
`define ASC_GRADE_35 2'h1
`define ASC_GRADE_45 2'h2
`define ASC_GRADE_55 2'h3
// read access time (address or select), per grade
`define ASC_T_ACC_25 25
`define ASC_T_ACC_35 35
`define ASC_T_ACC_45 45
`define ASC_T_ACC_55 55
// write pulse width, per grade
`define ASC_T_WP_25 20
`define ASC_T_WP_35 25
`define ASC_T_WP_45 35
`define ASC_T_WP_55 45
// write_to_output_off_time maximum, per grade
`define ASC_T_WOFF_25 15
`define ASC_T_WOFF_35 15
`define ASC_T_WOFF_45 20
`define ASC_T_WOFF_55 25
// address hold after write end, per grade (largest data hold 5 ns covered too)
`define ASC_T_HOLD_25 3
`define ASC_T_HOLD_35 3
`define ASC_T_HOLD_45 5
`define ASC_T_HOLD_55 5
// chip disable to output inactive
`define ASC_T_RELEASE 15
// cycle count: least time rounded up, at least one
`define ASC_CYC(t) ((((t) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS) < 1 ? 1 : \
	(((t) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS))
`endif

/* asc_sram_host.v */
/*
 * host controller for a 4K x 4 asynchronous sram with shared data pins.
 * assumes request inputs synchronous to core_clk_i and the sram wired to the pin ports.
 */
// Contract
// R1: drive twelve address lines with select low to pick one 4-bit word.
// R2: select high deselects the device; host idles with select high.
// R3: read holds write strobe high for the whole cycle with select low.
// R4: address change under low select starts a new read after access time.
// R5: select-started read: data valid after select access time.
// R6: select access time is independent of deselect duration.
// R7: write spans the time both select and write strobe are low.
// R8: host drives write data only after write-to-output-off time.
// R9: write-strobe-ended write lets device outputs come back on.
// R10: select-ended write keeps device outputs off afterwards.
// R11: strobe low before select falls keeps device outputs off.
// R12: address stable before write start, through end, held after.
// R13: select and write strobe held low at least pulse width.
// R14: data set up before terminating edge and held after it.
// R15: read data sampled no earlier than access time.
// R16: device releases bus within release time after select rises.
// R17: device drives again no sooner than 6 ns after strobe rise.
// R18: device is in standby within 30 ns after select rises.
// R19: speed grade parameter selects the timing limit set.
`default_nettype none
`include "asc_sram_regs.vh"
module asc_sram_host #(
	parameter [1:0] GRADE = `ASC_GRADE_25,
	parameter AW = `ASC_ADDR_W,
	parameter DW = `ASC_DATA_W
) (
	input wire core_clk_i,
	input wire rst_b_i,
	input wire clk_en_i,
	input wire req_valid_i,
	input wire req_write_i,
	input wire [AW-1:0] req_addr_i,
	input wire [DW-1:0] req_wdata_i,
	output wire req_ready_o,
	output reg rsp_valid_o,
	output reg [DW-1:0] rsp_rdata_o,
	output reg [AW-1:0] word_address_o,
	output reg sel_b_o,
	output reg wstrobe_b_o,
	output reg [DW-1:0] data_out_o,
	output reg data_oe_b_o,
	input wire [DW-1:0] data_in_i
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_READ = 2'h1;
	localparam [1:0] ST_WRITE = 2'h2;
	localparam [1:0] ST_RECOV = 2'h3;

	// per-grade limits; see R19
	localparam integer T_ACC =
		(GRADE == `ASC_GRADE_25) ? `ASC_T_ACC_25 :
		(GRADE == `ASC_GRADE_35) ? `ASC_T_ACC_35 :
		(GRADE == `ASC_GRADE_45) ? `ASC_T_ACC_45 :
		`ASC_T_ACC_55;
	localparam integer T_WP =
		(GRADE == `ASC_GRADE_25) ? `ASC_T_WP_25 :
		(GRADE == `ASC_GRADE_35) ? `ASC_T_WP_35 :
		(GRADE == `ASC_GRADE_45) ? `ASC_T_WP_45 :
		`ASC_T_WP_55;
	localparam integer T_WOFF =
		(GRADE == `ASC_GRADE_25) ? `ASC_T_WOFF_25 :
		(GRADE == `ASC_GRADE_35) ? `ASC_T_WOFF_35 :
		(GRADE == `ASC_GRADE_45) ? `ASC_T_WOFF_45 :
		`ASC_T_WOFF_55;
	localparam integer T_HOLD =
		(GRADE == `ASC_GRADE_25) ? `ASC_T_HOLD_25 :
		(GRADE == `ASC_GRADE_35) ? `ASC_T_HOLD_35 :
		(GRADE == `ASC_GRADE_45) ? `ASC_T_HOLD_45 :
		`ASC_T_HOLD_55;

	// whole-clock counts, cut to the counter width on purpose
	localparam integer N_ACC = `ASC_CYC(T_ACC);
	localparam integer N_WOFF = `ASC_CYC(T_WOFF);
	localparam integer N_WP = `ASC_CYC(T_WP);
	localparam integer N_REC = `ASC_CYC(`ASC_T_RELEASE);
	localparam integer N_HOLD = `ASC_CYC(T_HOLD);
	localparam [3:0] CYC_ACC = N_ACC[3:0];
	localparam [3:0] CYC_WOFF = N_WOFF[3:0];
	localparam [3:0] CYC_WP = N_WP[3:0];
	localparam [3:0] CYC_REC = N_REC[3:0];
	localparam [3:0] CYC_HOLD = N_HOLD[3:0];

	reg [1:0] state;
	reg [3:0] cnt;
	reg wphase;
	reg [1:0] next_state;
	reg [3:0] next_cnt;
	reg next_wphase;
	reg next_rsp_valid;
	reg [DW-1:0] next_rdata;
	reg [AW-1:0] next_addr;
	reg next_sel_b;
	reg next_wstrobe_b;
	reg [DW-1:0] next_dout;
	reg next_oe_b;

	assign req_ready_o = (state == ST_IDLE);

	always @* begin
		next_state = state;
		next_cnt = cnt;
		next_wphase = wphase;
		next_rsp_valid = 1'b0;
		next_rdata = rsp_rdata_o;
		next_addr = word_address_o;
		next_sel_b = sel_b_o;
		next_wstrobe_b = wstrobe_b_o;
		next_dout = data_out_o;
		next_oe_b = data_oe_b_o;
		case (state)
			ST_IDLE: begin
				if (req_valid_i) begin
					// address settles a cycle before any strobe falls; see R12
					next_addr = req_addr_i; // see R1
					next_dout = req_wdata_i;
					next_wphase = 1'b0;
					next_cnt = 4'h0;
					if (req_write_i) begin
						next_state = ST_WRITE;
					end else begin
						next_state = ST_READ;
					end
				end
			end

			ST_READ: begin
				next_sel_b = 1'b0; // see R3
				next_wstrobe_b = 1'b1;
				if (!sel_b_o) begin
					// wait full select access time before sampling; see R5 R6 R15
					if (cnt == CYC_ACC - 4'h1) begin
						next_rdata = data_in_i;
						next_rsp_valid = 1'b1;
						next_sel_b = 1'b1;
						next_cnt = 4'h0;
						next_state = ST_RECOV;
					end else begin
						next_cnt = cnt + 4'h1;
					end
				end
			end

			ST_WRITE: begin
				// strobe falls with select so device outputs never turn on; see R11 R7
				next_sel_b = 1'b0;
				next_wstrobe_b = 1'b0;
				if (!sel_b_o) begin
					if (!wphase) begin
						// keep bus quiet for the output-off time; see R8
						if (cnt == CYC_WOFF - 4'h1) begin
							next_oe_b = 1'b0;
							next_wphase = 1'b1;
							next_cnt = 4'h0;
						end else begin
							next_cnt = cnt + 4'h1;
						end
					end else if (cnt == CYC_WP - 4'h1) begin
						// data driven for setup and pulse width before end; see R13 R14
						// select rises with strobe: select ends write, outputs stay off; see R10
						next_sel_b = 1'b1;
						next_wstrobe_b = 1'b1;
						next_cnt = 4'h0;
						next_state = ST_RECOV;
					end else begin
						next_cnt = cnt + 4'h1;
					end
				end
			end

			ST_RECOV: begin
				// hold address and data, then let device release and power down; see R12 R14 R16 R18
				if (cnt == CYC_HOLD - 4'h1) begin
					next_oe_b = 1'b1;
				end
				if (cnt >= CYC_REC - 4'h1 && cnt >= CYC_HOLD - 4'h1) begin
					next_oe_b = 1'b1;
					next_cnt = 4'h0;
					next_state = ST_IDLE;
				end else begin
					next_cnt = cnt + 4'h1;
				end
			end

			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge core_clk_i) begin
		if (!rst_b_i) begin
			// deselected with the data pins released
			state <= ST_IDLE;
			cnt <= 4'h0;
			wphase <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_rdata_o <= {DW{1'b0}};
			word_address_o <= {AW{1'b0}};
			sel_b_o <= 1'b1; // see R2
			wstrobe_b_o <= 1'b1;
			data_out_o <= {DW{1'b0}};
			data_oe_b_o <= 1'b1;
		end else if (clk_en_i) begin
			// every register frozen while the enable is low
			state <= next_state;
			cnt <= next_cnt;
			wphase <= next_wphase;
			rsp_valid_o <= next_rsp_valid;
			rsp_rdata_o <= next_rdata;
			word_address_o <= next_addr;
			sel_b_o <= next_sel_b;
			wstrobe_b_o <= next_wstrobe_b;
			data_out_o <= next_dout;
			data_oe_b_o <= next_oe_b;
		end
	end

endmodule // asc_sram_host
`default_nettype wire

/* asc_sram_host_properties.sv */
/* pin checker of the sram host; bound to asc_sram_host, one clock */
`default_nettype none
module asc_sram_props (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic req_ready_o,
	input wire logic rsp_valid_o,
	input wire logic [11:0] word_address_o,
	input wire logic sel_b_o,
	input wire logic wstrobe_b_o,
	input wire logic [3:0] data_out_o,
	input wire logic data_oe_b_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence rd_take; req_valid_i && req_ready_o && clk_en_i && !req_write_i; endsequence
	sequence wr_end; !data_oe_b_o && !$past(data_oe_b_o) && $stable(data_out_o); endsequence
	AST_RD: assert property (rd_take |-> ##2 (!sel_b_o && wstrobe_b_o && data_oe_b_o) ##[1:3] rsp_valid_o)
		else $error("read cycle");
	AST_OFF: assert property ($fell(wstrobe_b_o) |-> data_oe_b_o) else $error("early data");
	AST_BOTH: assert property (!wstrobe_b_o |-> !sel_b_o) else $error("lone strobe");
	AST_ADR: assert property (!wstrobe_b_o || $rose(wstrobe_b_o) |-> $stable(word_address_o)) else $error("addr");
	AST_WID: assert property ($fell(wstrobe_b_o) |-> (!sel_b_o && !wstrobe_b_o)[*2]) else $error("pulse");
	AST_DAT: assert property ($rose(wstrobe_b_o) |-> wr_end ##1 data_oe_b_o) else $error("data setup");
endmodule // asc_sram_props
bind asc_sram_host asc_sram_props u_props (.*);
`default_nettype wire

/* asc_sram_dev.sv */
/* behavioural 4K x 4 sram; assumes the bench resolves the shared data pins */
`default_nettype none
module asc_sram_dev #(
	parameter int T_ACC = 25
) (
	input wire logic [11:0] addr_i,
	input wire logic sel_b_i,
	input wire logic we_b_i,
	input wire logic [3:0] bus_i,
	output logic [3:0] q_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] mem [4096];
	logic drv = 1'b0;
	logic ok = 1'b0;
	logic wr = 1'b0;
	// store at the terminating edge, where setup and hold are referenced
	always @(sel_b_i or we_b_i) begin
		if (!sel_b_i && !we_b_i) begin
			wr = 1'b1;
		end else if (wr) begin
			mem[addr_i] = bus_i;
			wr = 1'b0;
		end
	end
	always @(negedge sel_b_i) if (we_b_i) drv <= #5 1'b1;
	always @(posedge sel_b_i) drv <= #15 1'b0;
	always @(negedge we_b_i) drv <= #15 1'b0;
	always @(posedge we_b_i) if (!sel_b_i) drv <= #6 1'b1;
	always @(addr_i or negedge sel_b_i) begin
		ok <= #3 1'b0;
		ok <= #T_ACC 1'b1;
	end
	// complement while off so a mistimed sample cannot match
	assign q_o = (drv && ok) ? mem[addr_i] : ~mem[addr_i];
endmodule // asc_sram_dev
`default_nettype wire

/* tb_asc_sram_host.sv */
/* self-checking bench of the host against the sram model; assumes a 20 MHz clock */
`default_nettype none
module tb_asc_sram_host;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic clk_en_i = 1'b1;
	logic req_valid_i = 1'b0;
	logic req_write_i = 1'b0;
	logic [11:0] req_addr_i = 12'h000;
	logic [3:0] req_wdata_i = 4'h0;
	wire req_ready_o, rsp_valid_o, sel_b_o, wstrobe_b_o, data_oe_b_o;
	wire [11:0] word_address_o;
	wire [3:0] rsp_rdata_o, data_out_o, dev_q;
	wire [3:0] data_in_i = data_oe_b_o ? dev_q : data_out_o;
	int err_count = 0;
	int compares = 0;
	asc_sram_host dut (.*);
	asc_sram_dev u_dev (.addr_i(word_address_o), .sel_b_i(sel_b_o), .we_b_i(wstrobe_b_o), .bus_i(data_in_i),
		.q_o(dev_q));
	task automatic chk(input logic c, input string m);
		compares++;
		if (!c) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] d);
		int n = 0;
		while (req_ready_o !== 1'b1 && n < 20) begin @(posedge core_clk_i); #1; n++; end
		{req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'b1, w, a, d};
		@(posedge core_clk_i); #1;
		req_valid_i = 1'b0;
		while ((w ? req_ready_o : rsp_valid_o) !== 1'b1 && n < 40) begin @(posedge core_clk_i); #1; n++; end
		chk(n < 40, "hang");
	endtask
	task t_idle;
		chk({sel_b_o, wstrobe_b_o, data_oe_b_o, req_ready_o} === 4'hF, "idle pins");
	endtask
	task t_decode; // one word per address line, both extremes, then a rewrite
		for (int i = 0; i < 12; i++) xfer(1'b1, 12'h001 << i, i[3:0]);
		xfer(1'b1, 12'h000, 4'hC);
		xfer(1'b1, 12'hFFF, 4'h5);
		for (int i = 0; i < 12; i++) begin
			xfer(1'b0, 12'h001 << i, 4'h0);
			chk(rsp_rdata_o === i[3:0], "word");
		end
		xfer(1'b0, 12'h000, 4'h0);
		chk(rsp_rdata_o === 4'hC, "low end");
		xfer(1'b1, 12'hFFF, 4'hA);
		xfer(1'b0, 12'hFFF, 4'h0);
		chk(rsp_rdata_o === 4'hA, "rewrite");
	endtask
	task end_of_test;
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial forever #25 core_clk_i = ~core_clk_i;
	initial begin
		#100000;
		err_count++;
		end_of_test;
	end
	initial begin
		repeat (8) @(posedge core_clk_i);
		#1 rst_b_i = 1'b1;
		t_idle;
		t_decode;
		end_of_test;
	end
endmodule // tb_asc_sram_host
`default_nettype wire
